// *** common/ida_pkg.sv ***
/*
 * shared constants and types of the indirect data addressing unit:
 * file address map of pointer bytes and virtual access registers,
 * update modes, target classes, request and answer carriers.
 * assumes a 12-bit data space and an 8-bit core on one clock.
 */
package ida_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_PTR = 3;

    // ------------------------------------------------------------
    // file address map
    // ------------------------------------------------------------
    // virtual access registers: base + 8*pointer + mode offset
    localparam logic [11:0] VIRT_BASE = 12'hF00;
    localparam logic [2:0] MODE_OFS_PLAIN = 3'h0;
    localparam logic [2:0] MODE_OFS_POSTDEC = 3'h1;
    localparam logic [2:0] MODE_OFS_POSTINC = 3'h2;
    localparam logic [2:0] MODE_OFS_PREINC = 3'h3;
    localparam logic [2:0] MODE_OFS_INDEXED = 3'h4;
    // pointer bytes: base + 2*pointer, low byte first
    localparam logic [11:0] PTR_BASE = 12'hF20;

    // ------------------------------------------------------------
    // wishbone register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [3:0] WB_PTR0_OFS = 4'h0;
    localparam logic [3:0] WB_PTR1_OFS = 4'h4;
    localparam logic [3:0] WB_PTR2_OFS = 4'h8;
    localparam logic [3:0] WB_STAT_OFS = 4'hC;
    localparam int STAT_NULL_BIT = 16;
    localparam int STAT_PTRWR_BIT = 17;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [11:0] PTR_RST = 12'h000;
    localparam logic [7:0] NULL_READ_DATA = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_PLAIN, MODE_POSTDEC, MODE_POSTINC, MODE_PREINC, MODE_INDEXED
    } ida_mode_t;

    typedef enum logic [1:0] {TGT_MEM, TGT_PTR, TGT_NULL} ida_tgt_t;

    typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_DATA} ida_state_t;

    typedef struct packed {
        logic write;
        logic [11:0] addr;
        logic [7:0] wdata;
    } ida_req_t;

    typedef struct packed {
        logic done;
        logic [7:0] rdata;
        logic zeroSet;
        logic keepFlags;
    } ida_rsp_t;

endpackage : ida_pkg

// *** core/ida_core.sv ***
/*
 * indirect data addressing unit: three 12-bit pointers, five virtual
 * access registers per pointer, resolution of core file accesses to
 * data memory, and a classic wishbone slave for pointers and status.
 * assumes core and data memory share ref_clk; memory answers a read
 * in the cycle after memReq.
 */
`timescale 1ns/1ps
`default_nettype none

module ida_core (
    input wire logic ref_clk,
    input wire logic srst,
    // core side
    input wire ida_pkg::ida_req_t accReq,
    input wire logic accValid,
    input wire logic [7:0] workingRegister,
    output logic accReady,
    output ida_pkg::ida_rsp_t accRsp,
    // data memory side
    output logic memReq,
    output logic memWe,
    output logic [11:0] memAddr,
    output logic [7:0] memWData,
    input wire logic [7:0] memRData,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [11:0] ptr_reg [ida_pkg::NUM_PTR];
    ida_pkg::ida_state_t state_reg;
    ida_pkg::ida_tgt_t tgt_reg;
    logic [7:0] localData_reg;
    logic write_reg;
    logic [11:0] lastAddr_reg;
    logic lastNull_reg;
    logic lastPtrWr_reg;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    logic reqVirt;
    logic [1:0] reqIdx;
    ida_pkg::ida_mode_t reqMode;
    logic [11:0] ptrCur;
    logic [11:0] ptrStep;
    logic stepEn;
    logic [11:0] effAddr;
    logic effVirt;
    logic effPtr;
    logic [1:0] effIdx;
    logic effHigh;
    ida_pkg::ida_tgt_t tgt;
    logic accept;
    logic wbReq;
    logic wbPtrWr;
    logic [31:0] wbRdData;

    assign accept = accValid && accReady;
    assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // only aligned pointer offsets take a write; other bytes are unmapped
    assign wbPtrWr = wbReq && wb_we_i && wb_adr_i[1:0] == 2'h0 &&
        wb_adr_i[3:2] < 2'(ida_pkg::NUM_PTR);

    // any file address is first checked for a virtual register
    always_comb begin
        reqVirt = 1'b0;
        reqIdx = accReq.addr[4:3];
        reqMode = ida_pkg::MODE_PLAIN;
        if (accReq.addr[11:5] == ida_pkg::VIRT_BASE[11:5] &&
            accReq.addr[4:3] < 2'(ida_pkg::NUM_PTR)) begin
            reqVirt = 1'b1;
            if (accReq.addr[2:0] == ida_pkg::MODE_OFS_PLAIN) begin
                reqMode = ida_pkg::MODE_PLAIN;
            end else if (accReq.addr[2:0] == ida_pkg::MODE_OFS_POSTDEC) begin
                reqMode = ida_pkg::MODE_POSTDEC;
            end else if (accReq.addr[2:0] == ida_pkg::MODE_OFS_POSTINC) begin
                reqMode = ida_pkg::MODE_POSTINC;
            end else if (accReq.addr[2:0] == ida_pkg::MODE_OFS_PREINC) begin
                reqMode = ida_pkg::MODE_PREINC;
            end else if (accReq.addr[2:0] == ida_pkg::MODE_OFS_INDEXED) begin
                reqMode = ida_pkg::MODE_INDEXED;
            end else begin
                // offsets 5..7 of a slot are plain file addresses
                reqVirt = 1'b0;
            end
        end
    end

    // effective address and pointer step
    always_comb begin
        ptrCur = ptr_reg[reqIdx < 2'(ida_pkg::NUM_PTR) ? reqIdx : 2'd0];
        ptrStep = ptrCur;
        stepEn = 1'b0;
        effAddr = accReq.addr;
        if (reqVirt) begin
            case (reqMode)
                ida_pkg::MODE_PLAIN: begin
                    effAddr = ptrCur;
                end
                ida_pkg::MODE_POSTDEC: begin
                    effAddr = ptrCur;
                    ptrStep = ptrCur - 12'h001;
                    stepEn = 1'b1;
                end
                ida_pkg::MODE_POSTINC: begin
                    effAddr = ptrCur;
                    ptrStep = ptrCur + 12'h001;
                    stepEn = 1'b1;
                end
                ida_pkg::MODE_PREINC: begin
                    ptrStep = ptrCur + 12'h001;
                    effAddr = ptrStep;
                    stepEn = 1'b1;
                end
                ida_pkg::MODE_INDEXED: begin
                    // wraps inside the 4096-byte space
                    effAddr = ptrCur + {{4{workingRegister[7]}},
                        workingRegister};
                end
                default: begin
                    effAddr = ptrCur;
                end
            endcase
        end
    end

    // target class of the resolved address
    always_comb begin
        effVirt = effAddr[11:5] == ida_pkg::VIRT_BASE[11:5] &&
            effAddr[4:3] < 2'(ida_pkg::NUM_PTR) &&
            effAddr[2:0] <= ida_pkg::MODE_OFS_INDEXED;
        effPtr = effAddr[11:3] == ida_pkg::PTR_BASE[11:3] &&
            effAddr[2:1] < 2'(ida_pkg::NUM_PTR);
        effIdx = effAddr[2:1];
        effHigh = effAddr[0];
        if (reqVirt && effVirt) begin
            tgt = ida_pkg::TGT_NULL;
        end else if (effPtr) begin
            tgt = ida_pkg::TGT_PTR;
        end else begin
            tgt = ida_pkg::TGT_MEM;
        end
    end

    // ------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------
    // a core pointer-byte write or pointer step wins over a wishbone write in the same cycle, so
    // software must not rewrite a pointer while code walks it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < ida_pkg::NUM_PTR; i++) begin
                ptr_reg[i] <= ida_pkg::PTR_RST;
            end
        end else if (accept && accReq.write && tgt == ida_pkg::TGT_PTR) begin
            // the written byte dominates any step of the same pointer
            if (effHigh) begin
                ptr_reg[effIdx][11:8] <= accReq.wdata[3:0];
            end else begin
                ptr_reg[effIdx][7:0] <= accReq.wdata;
            end
            if (stepEn && effIdx != reqIdx) begin
                ptr_reg[reqIdx] <= ptrStep;
            end
        end else if (accept && stepEn) begin
            ptr_reg[reqIdx] <= ptrStep;
        end else if (wbPtrWr) begin
            // software write, only while the core leaves pointers alone
            if (wb_sel_i[0]) begin
                ptr_reg[wb_adr_i[3:2]][7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                ptr_reg[wb_adr_i[3:2]][11:8] <= wb_dat_i[11:8];
            end
        end
    end

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    // one access in flight; ready stays low until the answer
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ida_pkg::ST_IDLE;
            accReady <= 1'b0;
            tgt_reg <= ida_pkg::TGT_MEM;
            write_reg <= 1'b0;
        end else begin
            case (state_reg)
                ida_pkg::ST_IDLE: begin
                    accReady <= 1'b1;
                    if (accept) begin
                        state_reg <= ida_pkg::ST_MEM;
                        accReady <= 1'b0;
                        tgt_reg <= tgt;
                        write_reg <= accReq.write;
                    end
                end
                ida_pkg::ST_MEM: begin
                    state_reg <= ida_pkg::ST_DATA;
                end
                ida_pkg::ST_DATA: begin
                    state_reg <= ida_pkg::ST_IDLE;
                    accReady <= 1'b1;
                end
                default: begin
                    state_reg <= ida_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // memory request, one cycle after acceptance
    // pointer bytes and null targets stay local to the unit
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            memReq <= 1'b0;
            memWe <= 1'b0;
            memAddr <= 12'h000;
            memWData <= 8'h00;
        end else begin
            memReq <= 1'b0;
            memWe <= 1'b0;
            if (accept && tgt == ida_pkg::TGT_MEM) begin
                memReq <= 1'b1;
                memWe <= accReq.write;
                memAddr <= effAddr;
                memWData <= accReq.wdata;
            end
        end
    end

    // data that does not come from memory
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            localData_reg <= 8'h00;
        end else if (accept) begin
            if (tgt == ida_pkg::TGT_PTR) begin
                localData_reg <= effHigh ?
                    {4'h0, ptr_reg[effIdx][11:8]} : ptr_reg[effIdx][7:0];
            end else begin
                localData_reg <= ida_pkg::NULL_READ_DATA;
            end
        end
    end

    // answer to the core
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            accRsp <= '0;
        end else begin
            accRsp.done <= 1'b0;
            if (state_reg == ida_pkg::ST_DATA) begin
                accRsp.done <= 1'b1;
                accRsp.rdata <= tgt_reg == ida_pkg::TGT_MEM ?
                    memRData : localData_reg;
                // only a null read asks for zero; steps never do
                accRsp.zeroSet <= !write_reg &&
                    tgt_reg == ida_pkg::TGT_NULL;
                accRsp.keepFlags <= write_reg &&
                    tgt_reg == ida_pkg::TGT_NULL;
            end
        end
    end

    // status of the last access, for software
    // holds until the next accepted access, not cleared on read
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lastAddr_reg <= 12'h000;
            lastNull_reg <= 1'b0;
            lastPtrWr_reg <= 1'b0;
        end else if (accept) begin
            lastAddr_reg <= effAddr;
            lastNull_reg <= tgt == ida_pkg::TGT_NULL;
            lastPtrWr_reg <= accReq.write && tgt == ida_pkg::TGT_PTR;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    // read mux, decoded ahead of the register so that ack and data
    // leave flip-flops in the same cycle
    always_comb begin
        wbRdData = 32'h0000_0000;
        if (wb_adr_i == ida_pkg::WB_PTR0_OFS) begin
            wbRdData[11:0] = ptr_reg[0];
        end else if (wb_adr_i == ida_pkg::WB_PTR1_OFS) begin
            wbRdData[11:0] = ptr_reg[1];
        end else if (wb_adr_i == ida_pkg::WB_PTR2_OFS) begin
            wbRdData[11:0] = ptr_reg[2];
        end else if (wb_adr_i == ida_pkg::WB_STAT_OFS) begin
            wbRdData[11:0] = lastAddr_reg;
            wbRdData[ida_pkg::STAT_NULL_BIT] = lastNull_reg;
            wbRdData[ida_pkg::STAT_PTRWR_BIT] = lastPtrWr_reg;
        end
    end

    // pointer writes land at the request edge, the same edge that raises ack
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= 32'h0000_0000;
            if (wbReq && !wb_we_i) begin
                wb_dat_o <= wbRdData;
            end
        end
    end

endmodule : ida_core

`default_nettype wire

// *** dv/ida_props.sv ***
/* ida_props: port assertions for ida_core, bound below.
   assumes one clock ref_clk and synchronous active-high srst. */
`timescale 1ns/1ps
`default_nettype none
module ida_props (
    input wire logic ref_clk,
    input wire logic srst,
    input wire ida_pkg::ida_req_t accReq,
    input wire logic accValid,
    input wire logic accReady,
    input wire ida_pkg::ida_rsp_t accRsp,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [11:0] memAddr,
    input wire logic [7:0] memWData,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    // ----------------
    // checks
    // ----------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic take;
    logic plainMem;
    assign take = accValid && accReady;
    assign plainMem = take && (accReq.addr < 12'hF00);
    a_done_after_take: assert property (take |-> ##[2:3] accRsp.done)
        else $error("no done after accepted access");
    a_busy_refuses: assert property (take |=> !accReady)
        else $error("ready stayed high after accept");
    a_mem_from_take: assert property (memReq |-> $past(take))
        else $error("memory request without accepted access");
    a_mem_write_pass: assert property (plainMem && accReq.write |=>
        memReq && memWe && memAddr == $past(accReq.addr)
        && memWData == $past(accReq.wdata))
        else $error("direct write not passed to memory");
    a_mem_read_pass: assert property (plainMem && !accReq.write |=>
        memReq && !memWe && memAddr == $past(accReq.addr))
        else $error("direct read not passed to memory");
    a_null_reads_zero: assert property (accRsp.done && accRsp.zeroSet
        |-> accRsp.rdata == 8'h00)
        else $error("zero flag with nonzero data");
    a_write_no_zero: assert property (take && accReq.write |->
        ##[2:3] (accRsp.done && !accRsp.zeroSet))
        else $error("write answered with zero flag");
    a_ptr_byte_local: assert property (take
        && accReq.addr inside {[12'hF20:12'hF25]} |=> !memReq)
        else $error("pointer byte access reached memory");
    a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o)
        else $error("wishbone request not acknowledged");
    a_wb_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    c_null_read: cover property (accRsp.done && accRsp.zeroSet);
    c_keep_flags: cover property (accRsp.done && accRsp.keepFlags);
    c_wb_ack: cover property (wb_ack_o);
endmodule : ida_props
bind ida_core ida_props ida_props_u (.ref_clk, .srst, .accReq,
    .accValid, .accReady, .accRsp, .memReq, .memWe, .memAddr,
    .memWData, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire

// *** dv/ida_mem_model.sv ***
/* ida_mem_model: 4096-byte data memory behind the unit.
   assumes memReq pulses; read data valid the cycle after it. */
`timescale 1ns/1ps
`default_nettype none
module ida_mem_model (
    input wire logic ref_clk,
    input wire logic memReq,
    input wire logic memWe,
    input wire logic [11:0] memAddr,
    input wire logic [7:0] memWData,
    output logic [7:0] memRData
);
    // ----------------
    // storage
    // ----------------
    logic [7:0] store [4096];
    // data is shown one cycle only; it toggles after so late sampling fails
    always_ff @(posedge ref_clk) begin
        if (memReq && memWe) begin
            store[memAddr] <= memWData;
        end
        if (memReq && !memWe) begin
            memRData <= store[memAddr];
        end else begin
            memRData <= ~memRData;
        end
    end
endmodule : ida_mem_model
`default_nettype wire

// *** dv/tb_indirect_data_addressing.sv ***
/* tb_indirect_data_addressing: self-checking bench for ida_core.
   assumes ida_mem_model as data memory; 40 MHz ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module tb_indirect_data_addressing;
    // ----------------
    // signals
    // ----------------
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    ida_pkg::ida_req_t accReq = '0;
    logic accValid = 1'b0;
    logic [7:0] workingRegister = 8'h00;
    ida_pkg::ida_rsp_t accRsp;
    logic accReady, memReq, memWe, wb_ack_o;
    logic [11:0] memAddr;
    logic [7:0] memWData, memRData;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, wd;
    logic [11:0] seenAddr;
    logic [7:0] rd;
    logic sawMem, zs, kf;
    int mismatches = 0;
    int checked = 0;
    always #12.5 ref_clk = ~ref_clk;
    ida_core dut_u (.ref_clk, .srst, .accReq, .accValid,
        .workingRegister, .accReady, .accRsp, .memReq, .memWe,
        .memAddr, .memWData, .memRData, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    ida_mem_model mem_u (.ref_clk, .memReq, .memWe, .memAddr,
        .memWData, .memRData);
    // ----------------
    // tasks
    // ----------------
    task automatic give_verdict;
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string s, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask : chk
    task automatic hang(input string s);
        mismatches++;
        $display("unexpected %s: expected answer, seen none", s);
        give_verdict();
    endtask : hang
    // every access waits for done, so steps are seen by the next one
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [7:0] d, input logic [7:0] x);
        int n;
        accReq <= {w, a, d};
        workingRegister <= x;
        accValid <= 1'b1;
        sawMem = 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (accReady !== 1'b1 && n < 20);
        if (accReady !== 1'b1) hang("ready");
        accValid <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (memReq === 1'b1) begin
                sawMem = 1'b1;
                seenAddr = memAddr;
            end
        end while (accRsp.done !== 1'b1 && n < 20);
        if (accRsp.done !== 1'b1) hang("done");
        rd = accRsp.rdata;
        zs = accRsp.zeroSet;
        kf = accRsp.keepFlags;
    endtask : acc
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) hang("ack");
        wd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge ref_clk);
    endtask : wb
    // ----------------
    // scenarios
    // ----------------
    localparam logic [11:0] VA [6] = '{12'hF02, 12'hF00, 12'hF00,
        12'hF01, 12'hF00, 12'hF03};
    localparam logic [11:0] EA [6] = '{12'h0FF, 12'h100, 12'h100,
        12'h100, 12'h0FF, 12'h100};
    task automatic ptr_modes;
        acc(1'b1, 12'h0FF, 8'h11, 8'h00);
        acc(1'b1, 12'h100, 8'h22, 8'h00);
        acc(1'b1, 12'hF20, 8'hFF, 8'h00);
        acc(1'b1, 12'hF21, 8'h00, 8'h00);
        acc(1'b0, 12'hF20, 8'h00, 8'h00);
        chk("pointer low byte", 8'hFF, rd);
        acc(1'b0, 12'h100, 8'h00, 8'h00);
        chk("direct read", 8'h22, rd);
        chk("direct addr", 12'h100, seenAddr);
        wb(1'b0, 4'h0, 32'h0);
        chk("pointer0", 32'h0FF, wd);
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, VA[i], 8'h00, 8'h00);
            chk("step addr", EA[i], seenAddr);
            chk("step data", EA[i][8] ? 8'h22 : 8'h11, rd);
        end
    endtask : ptr_modes
    task automatic indexed;
        acc(1'b1, 12'h00F, 8'h33, 8'h00);
        wb(1'b1, 4'h4, 32'h010);
        acc(1'b0, 12'hF0C, 8'h00, 8'hFF);
        chk("index addr", 12'h00F, seenAddr);
        chk("index data", 8'h33, rd);
        acc(1'b0, 12'hF0C, 8'h00, 8'h7F);
        chk("index addr", 12'h08F, seenAddr);
        wb(1'b0, 4'h4, 32'h0);
        chk("pointer1", 32'h010, wd);
    endtask : indexed
    task automatic null_target;
        wb(1'b1, 4'h8, 32'hF08);
        acc(1'b0, 12'hF10, 8'h00, 8'h00);
        chk("null read", {1'b0, 1'b1, 8'h00}, {sawMem, zs, rd});
        acc(1'b1, 12'hF10, 8'h55, 8'h00);
        chk("null write", {1'b0, 1'b1, 1'b0}, {sawMem, kf, zs});
        wb(1'b0, 4'hC, 32'h0);
        chk("null status", 32'h0001_0F08, wd);
        wb(1'b0, 4'h8, 32'h0);
        chk("null keeps pointer", 32'hF08, wd);
        acc(1'b1, 12'h001, 8'h5A, 8'h00);
        wb(1'b1, 4'h8, 32'h001);
        acc(1'b0, 12'hF11, 8'h00, 8'h00);
        chk("step to zero", {1'b0, 8'h5A}, {zs, rd});
        wb(1'b0, 4'h8, 32'h0);
        chk("pointer2", 32'h000, wd);
    endtask : null_target
    task automatic own_byte;
        wb(1'b1, 4'h0, 32'hF20);
        acc(1'b1, 12'hF02, 8'h40, 8'h00);
        wb(1'b0, 4'h0, 32'h0);
        chk("own byte", 32'hF40, wd);
        chk("own byte mem", 1'b0, sawMem);
        wb(1'b0, 4'hC, 32'h0);
        chk("own byte status", 32'h0002_0F20, wd);
        wb(1'b1, 4'h1, 32'h0AB);
        wb(1'b0, 4'h1, 32'h0);
        chk("unmapped", 32'h0, wd);
        wb(1'b0, 4'h0, 32'h0);
        chk("unmapped write", 32'hF40, wd);
    endtask : own_byte
    // a second reset in mid-run must bring pointer0 back to zero
    task automatic mid_reset;
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        wb(1'b0, 4'h0, 32'h0);
        chk("pointer0 after reset", 32'h000, wd);
        acc(1'b0, 12'hF00, 8'h00, 8'h00);
        chk("reset addr", 12'h000, seenAddr);
    endtask : mid_reset
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        ptr_modes();
        indexed();
        null_target();
        own_byte();
        mid_reset();
        give_verdict();
    end
endmodule : tb_indirect_data_addressing
`default_nettype wire
